// ### lpmc_top.sv
// low-power mode controller: sequences run, sleep, low-power run/sleep,
// stop and standby, gates clocks and oscillators, and handles wakeup.
// assumes all inputs are synchronous to core_clk and that wake sources
// stay powered by the standby circuitry while the core domain is off.
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defs.svh"

module lpmc_top import lpmc_pkg::*; (
	input wire logic core_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire logic cmd_valid, // mode request strobe
	input wire lpmc_cmd_e cmd, // requested mode
	input wire logic cmd_rtc, // stop/standby keeps the clock
	input wire lpmc_osc_s osc_req, // run-mode oscillator choice
	input wire logic [2:0] msi_range, // multispeed osc range
	input wire logic rtc_on_lse, // clock fed by external slow osc
	input wire logic wdg_on, // independent_watchdog running
	input wire logic periph_irq, // any peripheral interrupt/event
	input wire lpmc_stopwake_s stop_wake, // stop wake lines
	input wire lpmc_rtcwake_s rtc_wake, // clock alarm/tamper/wake
	input wire logic [2:0] wake_pin, // standby wake pins
	input wire logic external_reset_pin_n, // external reset, low
	input wire logic wdg_reset, // independent_watchdog reset
	input wire logic [1:0] vrange, // voltage scaling range
	input wire logic [15:0] freq_khz, // present cpu frequency
	input wire logic src_is_msi, // cpu clock from multispeed osc
	input wire logic chg_valid, // frequency change request
	input wire logic [15:0] chg_khz, // requested frequency
	output lpmc_state_e state, // present mode
	output lpmc_gate_s gate, // clock and power controls
	output logic core_reset, // core domain reset on standby exit
	output logic cmd_refused, // request ignored this cycle
	output logic chg_ok, // frequency change allowed
	output logic flash_ws, // one flash wait state
	output logic freq_ok // frequency legal for range
);
	lpmc_state_e next_state;
	lpmc_gate_s next_gate;
	logic [11:0] cnt;
	logic [11:0] next_cnt;
	logic rtc_mode;
	logic next_rtc_mode;
	logic [2:0] pin_prev;
	logic next_core_reset;
	logic lp_ok;
	logic stop_any;
	logic stby_any;
	logic [2:0] pin_rise;
	logic [11:0] exit_wait;
	logic [11:0] next_exit_wait;
	localparam logic [11:0] STBY_EXIT_LIM = 12'(`LPMC_STBY_EXIT_CYC);

	// wake source decode; comparator events only count with the reference on
	always_comb begin
		pin_rise = wake_pin & ~pin_prev;
		stop_any = (|stop_wake.external_event_line) || stop_wake.supply_voltage_detector
			|| (stop_wake.int_ref_on && (|stop_wake.comp_event))
			|| stop_wake.usb_wake
			|| (rtc_mode && (|rtc_wake));
		stby_any = !external_reset_pin_n || (|pin_rise)
			|| (rtc_mode && (wdg_reset || (|rtc_wake)));
		lp_ok = src_is_msi && (msi_range <= `LPMC_MSI_LP_MAX_RANGE);
	end

	// mode sequencing
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rtc_mode = rtc_mode;
		cmd_refused = 1'b0;
		case (state)
			ST_RUN, ST_LPRUN: begin
				if (cmd_valid) begin
					case (cmd)
						CMD_SLEEP: next_state = (state == ST_LPRUN) ? ST_LPSLEEP : ST_SLEEP;
						CMD_RUN: next_state = ST_RUN;
						CMD_LPRUN: begin
							if (lp_ok) begin
								next_state = ST_LPRUN;
							end else begin
								cmd_refused = 1'b1;
							end
						end
						CMD_STOP: begin
							next_state = ST_STOP;
							next_rtc_mode = cmd_rtc;
						end
						CMD_STANDBY: begin
							next_state = ST_STANDBY;
							next_rtc_mode = cmd_rtc;
						end
						default: cmd_refused = 1'b1;
					endcase
				end
			end
			ST_SLEEP, ST_LPSLEEP: begin
				cmd_refused = cmd_valid;
				if (periph_irq) begin
					next_state = ST_RUN;
				end
			end
			ST_STOP: begin
				cmd_refused = cmd_valid;
				if (stop_any) begin
					next_state = ST_STOP_WAKE;
					next_cnt = `LPMC_STOP_SETTLE_CYC;
				end
			end
			ST_STOP_WAKE: begin
				// the core stays held until clocks and regulator are back
				cmd_refused = cmd_valid;
				next_cnt = cnt - 12'h001;
				if (cnt == 12'h001) begin
					next_state = ST_RUN;
				end
			end
			ST_STANDBY: begin
				cmd_refused = cmd_valid;
				if (stby_any) begin
					next_state = ST_STBY_EXIT;
					next_cnt = `LPMC_STBY_RST_CYC;
				end
			end
			ST_STBY_EXIT: begin
				cmd_refused = cmd_valid;
				next_cnt = cnt - 12'h001;
				if (cnt == 12'h001) begin
					next_state = ST_RUN;
					next_rtc_mode = 1'b0;
				end
			end
			default: next_state = ST_RUN;
		endcase
		next_core_reset = (next_state == ST_STBY_EXIT); // standby exit acts as a reset
		next_exit_wait = (next_state != ST_STBY_EXIT) ? 12'h000
			: exit_wait + {11'h000, exit_wait != 12'hFFF}; // saturates, so a stuck exit still trips
	end

	// gating follows the next state so gate and state change on the same edge
	always_comb begin
		next_gate = '0;
		next_gate.osc.low_speed_internal_osc = wdg_on;
		case (next_state)
			ST_RUN, ST_SLEEP: begin
				next_gate.cpu_clk_en = (next_state == ST_RUN);
				next_gate.periph_clk_en = 1'b1;
				next_gate.osc = osc_req;
				next_gate.osc.low_speed_internal_osc = osc_req.low_speed_internal_osc || wdg_on;
				next_gate.reg_main_on = 1'b1;
				next_gate.core_supply_domain = 1'b1;
				next_gate.retain = 1'b1;
			end
			ST_LPRUN, ST_LPSLEEP: begin
				// fast oscillators cannot run on the low-power regulator
				next_gate.cpu_clk_en = (next_state == ST_LPRUN);
				next_gate.periph_clk_en = 1'b1;
				next_gate.osc.multispeed_internal_osc = 1'b1;
				next_gate.osc.low_speed_internal_osc = osc_req.low_speed_internal_osc || wdg_on;
				next_gate.osc.low_speed_external_osc = osc_req.low_speed_external_osc;
				next_gate.reg_low_power = 1'b1;
				next_gate.core_supply_domain = 1'b1;
				next_gate.retain = 1'b1;
			end
			ST_STOP: begin
				// one slow oscillator for the clock, plus the watchdog's own
				next_gate.osc.low_speed_external_osc = next_rtc_mode && rtc_on_lse;
				next_gate.osc.low_speed_internal_osc = (next_rtc_mode && !rtc_on_lse) || wdg_on;
				next_gate.reg_low_power = 1'b1;
				next_gate.core_supply_domain = 1'b1;
				next_gate.retain = 1'b1;
			end
			ST_STANDBY: begin
				next_gate.osc.low_speed_external_osc = next_rtc_mode && rtc_on_lse;
				next_gate.osc.low_speed_internal_osc = (next_rtc_mode && !rtc_on_lse) || wdg_on;
			end
			ST_STOP_WAKE, ST_STBY_EXIT: begin
				next_gate.periph_clk_en = 1'b1;
				next_gate.osc.multispeed_internal_osc = 1'b1;
				next_gate.osc.low_speed_external_osc = rtc_mode && rtc_on_lse;
				next_gate.osc.low_speed_internal_osc = (rtc_mode && !rtc_on_lse) || wdg_on;
				next_gate.reg_main_on = 1'b1;
				next_gate.core_supply_domain = 1'b1;
				next_gate.retain = (next_state == ST_STOP_WAKE);
			end
			default: next_gate = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= ST_RUN;
			cnt <= 12'h000;
			rtc_mode <= 1'b0;
			pin_prev <= 3'h7; // no rising edge reported out of reset
			core_reset <= 1'b0;
			gate <= '0;
			exit_wait <= 12'h000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rtc_mode <= next_rtc_mode;
			pin_prev <= wake_pin;
			core_reset <= next_core_reset;
			gate <= next_gate;
			exit_wait <= next_exit_wait;
		end
	end

	lpmc_freq_guard u_guard (
		.core_clk(core_clk),
		.srst(srst),
		.vrange(vrange),
		.freq_khz(freq_khz),
		.src_is_msi(src_is_msi),
		.chg_valid(chg_valid),
		.chg_khz(chg_khz),
		.chg_ok(chg_ok),
		.flash_ws(flash_ws),
		.freq_ok(freq_ok)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence stop_resume_s;
		(state == ST_STOP_WAKE) ##[1:319] (state == ST_RUN && gate.cpu_clk_en);
	endsequence
	sequence stby_resume_s;
		(state == ST_STBY_EXIT && core_reset && exit_wait == 12'h001);
	endsequence

	sleep_gate_a: assert property (state == ST_SLEEP |-> !gate.cpu_clk_en && gate.periph_clk_en)
		else $error("sleep must stop only the cpu clock");
	sleep_wake_a: assert property (state == ST_SLEEP && periph_irq |=> state == ST_RUN)
		else $error("sleep did not wake on interrupt");
	lprun_osc_a: assert property (state == ST_LPRUN |-> gate.osc.multispeed_internal_osc
		&& gate.reg_low_power && !gate.osc.pll_en && !gate.osc.high_speed_external_osc)
		else $error("low-power run gating wrong");
	lpsleep_exit_a: assert property (state == ST_LPSLEEP && periph_irq
		|=> state == ST_RUN && gate.reg_main_on && !gate.reg_low_power)
		else $error("low-power sleep exit left regulator low");
	stop_rtc_osc_a: assert property (state == ST_STOP && rtc_mode |-> !gate.osc.pll_en
		&& !gate.osc.multispeed_internal_osc && !gate.osc.high_speed_internal_osc
		&& gate.retain && !gate.periph_clk_en
		&& (gate.osc.low_speed_external_osc != gate.osc.low_speed_internal_osc || wdg_on))
		else $error("stop with clock gating wrong");
	stop_exit_time_a: assert property (state == ST_STOP && stop_wake.usb_wake
		|=> stop_resume_s)
		else $error("stop exit too slow");
	stop_rtc_src_a: assert property (state == ST_STOP && !rtc_mode && !stop_any
		&& !cmd_valid |=> state == ST_STOP)
		else $error("stop left without a permitted source");
	stop_nortc_a: assert property (state == ST_STOP && !rtc_mode
		|-> !gate.osc.low_speed_external_osc && !gate.osc.high_speed_external_osc && !gate.osc.pll_en)
		else $error("oscillator left on in stop without clock");
	stby_off_a: assert property (state == ST_STANDBY
		|-> !gate.reg_main_on && !gate.core_supply_domain && !gate.retain)
		else $error("standby left core domain powered");
	stby_exit_a: assert property (state == ST_STANDBY && !external_reset_pin_n
		|=> stby_resume_s)
		else $error("standby exit did not start");
	stby_time_a: assert property (state == ST_STBY_EXIT |-> core_reset && exit_wait < STBY_EXIT_LIM)
		else $error("standby exit too slow");
	stby_ignore_a: assert property (state == ST_STANDBY && !rtc_mode && external_reset_pin_n
		&& pin_rise == 3'h0 |=> state == ST_STANDBY)
		else $error("standby without clock left on a foreign source");
	wdg_clock_a: assert property (state == ST_STANDBY && $past(state) == ST_STANDBY
		&& $past(wdg_on) |-> gate.osc.low_speed_internal_osc)
		else $error("watchdog clock stopped in standby");
	stop_wake_a: assert property (state == ST_STOP_WAKE |-> gate.reg_main_on
		&& gate.periph_clk_en && !gate.cpu_clk_en && gate.retain)
		else $error("cpu released before clocks restored");

endmodule // lpmc_top
`default_nettype wire

// ### lpmc_defs.svh
// offsets-free constant set for the low-power mode controller: timing counts,
// frequency limits and voltage-range codes.
// assumes a single 40 MHz core clock; frequencies are carried in kHz.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

`define LPMC_CLK_PERIOD_NS 25
// stop exit must finish within this time (longest time, rounds down)
`define LPMC_STOP_WAKE_NS 8000
`define LPMC_STOP_WAKE_CYC (`LPMC_STOP_WAKE_NS / `LPMC_CLK_PERIOD_NS)
// standby exit must finish within this time (longest time, rounds down)
`define LPMC_STBY_EXIT_NS 60000
`define LPMC_STBY_EXIT_CYC (`LPMC_STBY_EXIT_NS / `LPMC_CLK_PERIOD_NS)
// least spacing between two cpu frequency changes (least time, rounds up)
`define LPMC_PACE_NS 5000
`define LPMC_PACE_CYC ((`LPMC_PACE_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)
// settle counts inside the exit windows
`define LPMC_STOP_SETTLE_CYC 12'h010
`define LPMC_STBY_RST_CYC 12'h040

// voltage scaling range codes
`define LPMC_VR_1 2'h1
`define LPMC_VR_2 2'h2
`define LPMC_VR_3 2'h3

// cpu frequency ceilings per range, kHz
`define LPMC_MAX_R1_KHZ 16'h7D00
`define LPMC_MAX_R2_KHZ 16'h3E80
`define LPMC_MAX_R3_KHZ 16'h0FA0
// one flash wait state above these, kHz
`define LPMC_WS_R1_KHZ 16'h3E80
`define LPMC_WS_R2_KHZ 16'h1F40
`define LPMC_WS_R3_KHZ 16'h0834
// highest multispeed oscillator range allowed in low-power run
`define LPMC_MSI_LP_MAX_RANGE 3'h1

`endif

// ### lpmc_pkg.sv
// types shared by the low-power mode controller and its frequency guard.
// assumes lpmc_defs.svh supplies the numeric constants.
package lpmc_pkg;

	// one-hot controller states
	typedef enum logic [7:0] {
		ST_RUN       = 8'h01,
		ST_SLEEP     = 8'h02,
		ST_LPRUN     = 8'h04,
		ST_LPSLEEP   = 8'h08,
		ST_STOP      = 8'h10,
		ST_STOP_WAKE = 8'h20,
		ST_STANDBY   = 8'h40,
		ST_STBY_EXIT = 8'h80
	} lpmc_state_e;

	// mode requests from the core
	typedef enum logic [2:0] {
		CMD_RUN     = 3'h0,
		CMD_SLEEP   = 3'h1,
		CMD_LPRUN   = 3'h2,
		CMD_STOP    = 3'h3,
		CMD_STANDBY = 3'h4
	} lpmc_cmd_e;

	// oscillator enables requested by software for run mode
	typedef struct packed {
		logic pll_en;
		logic high_speed_internal_osc;
		logic high_speed_external_osc;
		logic multispeed_internal_osc;
		logic low_speed_internal_osc;
		logic low_speed_external_osc;
	} lpmc_osc_s;

	// clock, oscillator and power controls driven out
	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		lpmc_osc_s osc;
		logic reg_main_on;
		logic reg_low_power;
		logic core_supply_domain;
		logic retain;
	} lpmc_gate_s;

	// stop-mode wake sources
	typedef struct packed {
		logic [15:0] external_event_line;
		logic supply_voltage_detector;
		logic [1:0] comp_event;
		logic int_ref_on;
		logic usb_wake;
	} lpmc_stopwake_s;

	// clock-domain sources that wake stop and standby
	typedef struct packed {
		logic [1:0] alarm;
		logic tamper;
		logic timestamp;
		logic periodic_wake;
	} lpmc_rtcwake_s;

endpackage

// ### lpmc_freq_guard.sv
// frequency guard: flash wait states, range ceiling check and change pacing.
// assumes frequency inputs are stable kHz values synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defs.svh"

module lpmc_freq_guard import lpmc_pkg::*; (
	input wire logic core_clk, // 40 MHz clock
	input wire logic srst, // synchronous reset, high
	input wire logic [1:0] vrange, // voltage scaling range
	input wire logic [15:0] freq_khz, // present cpu frequency
	input wire logic src_is_msi, // cpu clock from multispeed osc
	input wire logic chg_valid, // frequency change request
	input wire logic [15:0] chg_khz, // requested final frequency
	output logic chg_ok, // change may be applied now
	output logic flash_ws, // one flash wait state
	output logic freq_ok // present frequency legal
);
	logic [7:0] pace_cnt;
	logic [7:0] next_pace_cnt;
	logic next_ws;
	logic next_ok;
	localparam logic [7:0] PACE_CYC = 8'(`LPMC_PACE_CYC);

	// ceiling for the selected range
	function automatic logic [15:0] range_max(input logic [1:0] vr);
		case (vr)
			`LPMC_VR_1: range_max = `LPMC_MAX_R1_KHZ;
			`LPMC_VR_2: range_max = `LPMC_MAX_R2_KHZ;
			default: range_max = `LPMC_MAX_R3_KHZ;
		endcase
	endfunction

	// wait-state threshold for the selected range
	function automatic logic [15:0] ws_thresh(input logic [1:0] vr);
		case (vr)
			`LPMC_VR_1: ws_thresh = `LPMC_WS_R1_KHZ;
			`LPMC_VR_2: ws_thresh = `LPMC_WS_R2_KHZ;
			default: ws_thresh = `LPMC_WS_R3_KHZ;
		endcase
	endfunction

	// a change is refused while pacing, on a drop to a quarter or less, or past the ceiling
	always_comb begin
		chg_ok = (pace_cnt == 8'h00) && ({2'h0, freq_khz} < {chg_khz, 2'h0})
			&& (chg_khz <= range_max(vrange)) && (vrange != `LPMC_VR_3 || src_is_msi);
		next_pace_cnt = pace_cnt;
		if (chg_valid && chg_ok) begin
			next_pace_cnt = PACE_CYC;
		end else if (pace_cnt != 8'h00) begin
			next_pace_cnt = pace_cnt - 8'h01;
		end
		next_ws = freq_khz > ws_thresh(vrange);
		next_ok = (freq_khz <= range_max(vrange)) && (vrange != `LPMC_VR_3 || src_is_msi);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pace_cnt <= 8'h00;
			flash_ws <= 1'b1; // safe side until the first frequency is seen
			freq_ok <= 1'b0;
		end else begin
			pace_cnt <= next_pace_cnt;
			flash_ws <= next_ws;
			freq_ok <= next_ok;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	pace_hold_a: assert property ((chg_valid && chg_ok) |=> !chg_ok [*8])
		else $error("frequency change accepted inside pacing gap");
	range3_src_a: assert property (!src_is_msi && vrange == `LPMC_VR_3 |-> !chg_ok)
		else $error("range 3 change allowed without multispeed source");
	ws_map_a: assert property ((vrange == `LPMC_VR_2 && $stable(vrange) && freq_khz > 16'h1F40)
		|=> flash_ws)
		else $error("wait state missing above range 2 threshold");

endmodule // lpmc_freq_guard
`default_nettype wire

// ### lpmc_wake_model.sv
// wake source model: the core's interrupt line and every wake input.
// assumes the bench names one source per cycle on kick; 0 = all quiet.
`timescale 1ns/10ps
`default_nettype none

module lpmc_wake_model import lpmc_pkg::*; (
	input wire logic [3:0] kick, // source to fire this cycle
	input wire logic int_ref_on, // internal reference on
	output var lpmc_stopwake_s stop_wake, // stop wake lines
	output var lpmc_rtcwake_s rtc_wake, // clock wake sources
	output logic [2:0] wake_pin, // standby wake pins
	output logic periph_irq, // peripheral interrupt
	output logic external_reset_pin_n, // external reset, low
	output logic wdg_reset // watchdog reset
);
	// sources are events, so a quiet line returns to its idle level
	always_comb begin
		stop_wake = '0;
		stop_wake.int_ref_on = int_ref_on;
		rtc_wake = '0;
		wake_pin = 3'h0; // low between events so each kick is a rise
		periph_irq = (kick == 4'h1);
		stop_wake.external_event_line[3] = (kick == 4'h2);
		rtc_wake.alarm[0] = (kick == 4'h3);
		stop_wake.comp_event[0] = (kick == 4'h4);
		stop_wake.usb_wake = (kick == 4'h5);
		wake_pin[2] = (kick == 4'h6);
		wdg_reset = (kick == 4'h7);
		external_reset_pin_n = (kick != 4'h8);
	end
endmodule // lpmc_wake_model

`default_nettype wire

// ### low_power_mode_controller_tb.sv
// self-checking bench for the low-power mode controller.
// assumes lpmc_wake_model drives the wake side; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defs.svh"

module low_power_mode_controller_tb import lpmc_pkg::*;;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic cmd_valid = 1'b0;
	lpmc_cmd_e cmd = CMD_RUN;
	logic cmd_rtc = 1'b0;
	lpmc_osc_s osc_req = 6'h14;
	logic [2:0] msi_range = 3'h1;
	logic rtc_on_lse = 1'b1;
	logic wdg_on = 1'b0;
	logic int_ref_on = 1'b0;
	logic [3:0] kick_c = 4'h0;
	logic [1:0] vrange = 2'h1;
	logic [15:0] freq_khz = 16'h3E80;
	logic src_is_msi = 1'b1;
	logic chg_valid = 1'b0;
	logic [15:0] chg_khz = 16'h3E80;
	lpmc_stopwake_s stop_wake;
	lpmc_rtcwake_s rtc_wake;
	logic [2:0] wake_pin;
	logic periph_irq, external_reset_pin_n, wdg_reset;
	lpmc_state_e state;
	lpmc_gate_s gate;
	logic core_reset, cmd_refused, chg_ok, flash_ws, freq_ok, refd;
	int fails = 0;
	int num_checks = 0;
	int n;
	logic [23:0] ftab [10] = '{24'h153E80, 24'h173E81, 24'h167D01, 24'h251F40,
		24'h271F41, 24'h263E81, 24'h350834, 24'h370835, 24'h360FA1, 24'h320BB8};

	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;

	lpmc_wake_model wake_u (.kick(kick_c), .int_ref_on(int_ref_on), .stop_wake(stop_wake),
		.rtc_wake(rtc_wake), .wake_pin(wake_pin), .periph_irq(periph_irq),
		.external_reset_pin_n(external_reset_pin_n), .wdg_reset(wdg_reset));

	lpmc_top dut_u (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_rtc(cmd_rtc), .osc_req(osc_req), .msi_range(msi_range),
		.rtc_on_lse(rtc_on_lse), .wdg_on(wdg_on), .periph_irq(periph_irq),
		.stop_wake(stop_wake), .rtc_wake(rtc_wake), .wake_pin(wake_pin),
		.external_reset_pin_n(external_reset_pin_n), .wdg_reset(wdg_reset),
		.vrange(vrange), .freq_khz(freq_khz), .src_is_msi(src_is_msi),
		.chg_valid(chg_valid), .chg_khz(chg_khz), .state(state), .gate(gate),
		.core_reset(core_reset), .cmd_refused(cmd_refused), .chg_ok(chg_ok),
		.flash_ws(flash_ws), .freq_ok(freq_ok));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic step();
		@(posedge core_clk);
		#1;
	endtask

	// one request pulse; refusal is combinational so it is read mid-pulse
	task automatic go(input lpmc_cmd_e c, input logic r);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_rtc <= r;
		#1 refd = cmd_refused;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		#1;
	endtask

	task automatic kick(input logic [3:0] k);
		@(posedge core_clk);
		kick_c <= k;
		@(posedge core_clk);
		kick_c <= 4'h0;
		#1;
	endtask

	// bounded wait for run; a hang counts as a mismatch
	task automatic wait_run(input int lim);
		n = 0;
		while (state !== ST_RUN && n < lim) begin
			step();
			n++;
		end
		if (state !== ST_RUN) begin
			fails++;
			end_of_test();
		end
	endtask

	initial begin
		repeat (15) @(posedge core_clk);
		#1 chk("rst_state", state, ST_RUN);
		chk("rst_ws", flash_ws, 1'b1);
		@(posedge core_clk);
		srst <= 1'b0;
		step();
		step();
		chk("run_cpu", gate.cpu_clk_en, 1'b1);
		chk("run_osc", gate.osc, osc_req);
		$display("test reset done");
		// sleep: only the cpu clock stops, refusals in sleep and of a bad command
		go(CMD_SLEEP, 1'b0);
		chk("slp", state, ST_SLEEP);
		chk("slp_cpu", gate.cpu_clk_en, 1'b0);
		chk("slp_per", gate.periph_clk_en, 1'b1);
		go(CMD_STOP, 1'b0);
		chk("slp_ref", refd, 1'b1);
		kick(4'h1);
		chk("slp_wake", state, ST_RUN);
		go(lpmc_cmd_e'(3'h7), 1'b0);
		chk("bad_cmd", refd, 1'b1);
		$display("test sleep done");
		// low-power run needs a slow multispeed range
		msi_range <= 3'h2;
		go(CMD_LPRUN, 1'b0);
		chk("lp_ref", refd, 1'b1);
		chk("lp_ref_st", state, ST_RUN);
		msi_range <= 3'h1;
		go(CMD_LPRUN, 1'b0);
		chk("lprun", state, ST_LPRUN);
		chk("lp_reg", gate.reg_low_power, 1'b1);
		go(CMD_RUN, 1'b0);
		chk("lp_to_run", state, ST_RUN);
		go(CMD_LPRUN, 1'b0);
		chk("lprun2", state, ST_LPRUN);
		go(CMD_SLEEP, 1'b0);
		chk("lpslp", state, ST_LPSLEEP);
		kick(4'h1);
		chk("lps_wake", state, ST_RUN);
		chk("lps_main", gate.reg_main_on, 1'b1);
		$display("test lowpower done");
		// stop keeping the clock: one slow osc, clock sources wake
		go(CMD_STOP, 1'b1);
		chk("stp", state, ST_STOP);
		chk("stp_osc", gate.osc, 6'h01);
		chk("stp_lp", gate.reg_low_power, 1'b1);
		chk("stp_ret", gate.retain, 1'b1);
		chk("stp_cpu", gate.cpu_clk_en, 1'b0);
		kick(4'h4);
		chk("cmp_noref", state, ST_STOP);
		kick(4'h3);
		chk("stp_wk", state, ST_STOP_WAKE);
		chk("wk_main", gate.reg_main_on, 1'b1);
		chk("wk_cpu", gate.cpu_clk_en, 1'b0);
		wait_run(320);
		chk("stp_cyc", 16'(n), 16'h0010);
		chk("stp_back", gate.cpu_clk_en, 1'b1);
		// stop without the clock: all off but the watchdog's osc, clock sources ignored
		go(CMD_STOP, 1'b0);
		chk("s0_osc", gate.osc, 6'h00);
		kick(4'h3);
		chk("s0_alarm", state, ST_STOP);
		int_ref_on <= 1'b1;
		kick(4'h4);
		chk("s0_cmp", state, ST_STOP_WAKE);
		wait_run(320);
		wdg_on <= 1'b1;
		go(CMD_STOP, 1'b0);
		chk("s0_wdg", gate.osc, 6'h02);
		kick(4'h5);
		chk("s0_usb", state, ST_STOP_WAKE);
		wait_run(320);
		go(CMD_STOP, 1'b0);
		kick(4'h2);
		chk("s0_line", state, ST_STOP_WAKE);
		wait_run(320);
		wdg_on <= 1'b0;
		$display("test stop done");
		// standby keeping the clock
		go(CMD_STANDBY, 1'b1);
		chk("sb", state, ST_STANDBY);
		chk("sb_reg", gate.reg_main_on, 1'b0);
		chk("sb_dom", gate.core_supply_domain, 1'b0);
		chk("sb_ret", gate.retain, 1'b0);
		chk("sb_lse", gate.osc.low_speed_external_osc, 1'b1);
		kick(4'h7);
		chk("sb_wdg", state, ST_STBY_EXIT);
		chk("sb_rst", core_reset, 1'b1);
		wait_run(2400);
		chk("sb_cyc", 16'(n), 16'h0040);
		chk("sb_rst0", core_reset, 1'b0);
		// standby without the clock: only pins and reset exit
		go(CMD_STANDBY, 1'b0);
		kick(4'h7);
		chk("s1_wdg", state, ST_STANDBY);
		kick(4'h3);
		chk("s1_alarm", state, ST_STANDBY);
		kick(4'h6);
		chk("s1_pin", state, ST_STBY_EXIT);
		wait_run(2400);
		go(CMD_STANDBY, 1'b0);
		kick(4'h8);
		chk("s1_external_reset_pin", state, ST_STBY_EXIT);
		wait_run(2400);
		$display("test standby done");
		// wait state and ceiling at each range boundary
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			vrange <= ftab[i][21:20];
			src_is_msi <= ftab[i][18];
			freq_khz <= ftab[i][15:0];
			step();
			step();
			chk("ws", flash_ws, ftab[i][17]);
			chk("fok", freq_ok, ftab[i][16]);
		end
		$display("test ranges done");
		// step ratio, ceiling and 5 us pacing
		@(posedge core_clk);
		vrange <= `LPMC_VR_1;
		src_is_msi <= 1'b1;
		freq_khz <= 16'h3E80;
		chg_khz <= 16'h0FA0;
		#1 chk("ratio_lo", chg_ok, 1'b0);
		@(posedge core_clk);
		chg_khz <= 16'h7D01;
		#1 chk("ceil", chg_ok, 1'b0);
		@(posedge core_clk);
		chg_khz <= 16'h0FA1;
		#1 chk("ratio_ok", chg_ok, 1'b1);
		@(posedge core_clk);
		chg_valid <= 1'b1;
		@(posedge core_clk);
		chg_valid <= 1'b0;
		#1 n = 0;
		while (chg_ok !== 1'b1 && n < 300) begin
			n++;
			step();
		end
		chk("pace", 16'(n), 16'h00C8);
		$display("test pacing done");
		end_of_test();
	end
endmodule // low_power_mode_controller_tb

`default_nettype wire
